// [include/scg_defines.vh]
// Purpose: constants for the system clock generator control block
// Assumes: APB byte address = register index * 4
// Notes:   indices, field positions, reset values and timing counts
`ifndef SCG_DEFINES_VH
`define SCG_DEFINES_VH

// register indices
`define SCG_IDX_BOOT_OPT      24'h0000C2
`define SCG_IDX_FAST_DIV      24'h0F00A8
`define SCG_IDX_OSC_MODE      24'h0F00B0
`define SCG_IDX_STAB_SEL      24'h0F00B1
`define SCG_IDX_RUN_CTRL      24'h0F00B2
`define SCG_IDX_STAB_STAT     24'h0F00B3
`define SCG_IDX_SYS_CLK       24'h0F00B4
`define SCG_IDX_SUB_SUPPLY    24'h0F00B5

// reset values
`define SCG_RST_OSC_MODE      8'h00
`define SCG_RST_STAB_SEL      3'h7
`define SCG_RST_RUN_CTRL      8'hC0
`define SCG_RST_SUB_SUPPLY    8'h00

// boot option byte fields
`define SCG_OPT_FLASH_HI      7
`define SCG_OPT_FLASH_LO      6
`define SCG_OPT_FREQ_HI       4
`define SCG_OPT_FREQ_B3       3

// oscillator mode fields
`define SCG_MODE_MAIN_EXT     7
`define SCG_MODE_MAIN_PIN     6
`define SCG_MODE_SUB_EXT      5
`define SCG_MODE_SUB_PIN      4
`define SCG_MODE_SUB_DRV_HI   2
`define SCG_MODE_SUB_DRV_LO   1
`define SCG_MODE_MAIN_GAIN    0

// run control fields
`define SCG_RUN_MAIN_HALT     7
`define SCG_RUN_SUB_HALT      6
`define SCG_RUN_FAST_HALT     0

// system clock control fields
`define SCG_SYS_ON_SUB        7
`define SCG_SYS_SRC_SUB       6
`define SCG_SYS_MAIN_STAT     5
`define SCG_SYS_MAIN_SEL      4

// subsystem supply fields
`define SCG_SUP_LOW_POWER     7
`define SCG_SUP_ITMR_SLOW     4

// clock sources
`define SCG_SRC_FAST          2'd0
`define SCG_SRC_MAIN          2'd1
`define SCG_SRC_SUB           2'd2

// frequencies in MHz
`define SCG_BASE_HI_MHZ       8'd32
`define SCG_BASE_LO_MHZ       8'd24
`define SCG_DIV4_MHZ          8'd2
`define SCG_DIV5_MHZ          8'd1

// timing
`define SCG_PCLK_MHZ          50
`define SCG_RST_PROC_US       135
`define SCG_RST_PROC_CYC      (`SCG_RST_PROC_US * `SCG_PCLK_MHZ)
`define SCG_SWITCH_GAP_CYC    4
`define SCG_STAB_CNT_W        19

`endif

// [design/scg_src_switch.v]
// Purpose: break-before-make sequencing of the cpu clock source select
// Assumes: selects drive an external glitch-free clock mux
// Notes:   all selects low for a gap before the new one rises
`timescale 1ns/1ps
`default_nettype none
`include "scg_defines.vh"

module scg_src_switch #(
   parameter GAP_CYC = `SCG_SWITCH_GAP_CYC
) (
   input  wire       pclk,      // system clock
   input  wire       presetn,   // async reset, active low
   input  wire [1:0] req_src,   // requested source
   output reg  [1:0] cur_src,   // source in use
   output reg  [2:0] sel_onehot // mux selects: sub, main, fast
);

   localparam ST_RUN = 1'b0;
   localparam ST_GAP = 1'b1;

   reg       state_r;
   reg [3:0] gap_cnt_r;
   reg [1:0] tgt_r;

   function [2:0] onehot;
      input [1:0] src;
      begin
         case (src)
            `SCG_SRC_MAIN: onehot = 3'h2;
            `SCG_SRC_SUB:  onehot = 3'h4;
            default:       onehot = 3'h1;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r    <= ST_RUN;
         gap_cnt_r  <= 4'h0;
         tgt_r      <= `SCG_SRC_FAST;
         cur_src    <= `SCG_SRC_FAST;
         sel_onehot <= 3'h1;
      end else begin
         case (state_r)
            ST_RUN: begin
               if (req_src != cur_src) begin
                  // old select drops first so no runt pulse reaches the cpu
                  sel_onehot <= 3'h0;
                  tgt_r      <= req_src;
                  gap_cnt_r  <= GAP_CYC[3:0];
                  state_r    <= ST_GAP;
               end
            end
            ST_GAP: begin
               if (gap_cnt_r == 4'h1) begin
                  sel_onehot <= onehot(tgt_r);
                  cur_src    <= tgt_r;
                  state_r    <= ST_RUN;
               end else begin
                  gap_cnt_r <= gap_cnt_r - 4'h1;
               end
            end
            default: state_r <= ST_RUN;
         endcase
      end
   end

endmodule
`default_nettype wire

// [design/scg_clock_ctrl.v]
// Purpose: system clock generator control with APB register access
// Assumes: oscillators and glitch-free clock mux sit outside this block
// Notes:   oscillator pins and supply sense are synchronised to pclk
//
// Summary of operation
// - fast internal oscillator runs after reset release without software action
// - cpu clock starts on fast oscillator; cpu waits a reset processing time
// - internal reset held until supply is inside operating range
// - codes 11000 and 10000 give 64/48 MHz raw, halved to 32/24
// - other valid codes give 32 down to 1 MHz undivided; rest prohibited
// - divider register holds bits 2:0, upper bits zero, changes frequency live
// - divider 0..3 divides base by 1..8; 4,5 give 2,1 MHz on the 32 MHz base only
// - clearing main halt bit starts the main crystal oscillator
// - stabilization status flags set progressively from bit 7 downward
// - main source select bit moves cpu clock to main crystal
// - low power bit gives sub clock only to rtc and interval timer in standby while the cpu runs on sub clock
// - clearing sub halt bit starts the sub crystal oscillator
// - cpu source sub bit moves cpu clock to sub crystal
// - main and sub oscillators stay stopped after reset
// - oscillator mode register accepts one write per reset
// - pin pair encodes resonator, external input or input port mode
// - bit 0 of run control stops or runs the fast oscillator
`timescale 1ns/1ps
`default_nettype none
`include "scg_defines.vh"

module scg_clock_ctrl #(
   parameter RST_PROC_CYC = `SCG_RST_PROC_CYC,
   parameter GAP_CYC      = `SCG_SWITCH_GAP_CYC
) (
   input  wire        pclk,              // system clock, 50 MHz
   input  wire        presetn,           // async reset, active low
   input  wire        psel,              // apb select
   input  wire        penable,           // apb enable
   input  wire        pwrite,            // apb direction
   input  wire [23:0] paddr,             // apb byte address
   input  wire [31:0] pwdata,            // apb write data
   output wire        pready,            // apb ready
   output reg  [31:0] prdata,            // apb read data
   output reg         pslverr,           // apb error
   input  wire [7:0]  boot_option,       // boot option byte from flash
   input  wire        supply_ok,         // supply inside operating range
   input  wire        main_xtal_clk,     // main oscillator output pin
   input  wire        cpu_standby,       // cpu in stop or halt
   output reg         cpu_reset_n,       // internal reset, active low
   output wire        fast_osc_en,       // fast oscillator run
   output wire        main_osc_en,       // main resonator run
   output wire        main_ext_clk_en,   // main external input run
   output wire        main_gain_high,    // main resonator high gain
   output wire        sub_osc_en,        // sub resonator run
   output wire        sub_ext_clk_en,    // sub external input run
   output wire [1:0]  sub_drive_mode,    // sub oscillation mode
   output reg  [7:0]  fast_osc_mhz,      // fast oscillator clock, MHz
   output reg  [7:0]  fast_osc_raw_mhz,  // raw oscillator frequency, MHz
   output wire [1:0]  flash_mode,        // flash operation mode
   output wire [2:0]  stab_time_sel,     // stop wake-up stabilization select
   output wire [2:0]  clk_sel_onehot,    // cpu clock mux: sub, main, fast
   output wire        sub_clk_periph_en, // sub clock to general peripherals
   output wire        sub_clk_rtc_en     // sub clock to rtc and interval timer
);

   localparam RP_SUPPLY = 2'd0;
   localparam RP_COUNT  = 2'd1;
   localparam RP_DONE   = 2'd2;

   reg  [1:0]  rp_state_r;
   reg  [15:0] rp_cnt_r;
   reg  [7:0]  opt_s1_r;
   reg  [7:0]  opt_s2_r;
   reg  [7:0]  boot_opt_r;
   reg         sup_s1_r;
   reg         sup_s2_r;
   reg         mx_s1_r;
   reg         mx_s2_r;
   reg         mx_s3_r;
   reg  [2:0]  fast_div_r;
   reg  [7:0]  osc_mode_r;
   reg         mode_written_r;
   reg  [2:0]  stab_sel_r;
   reg  [7:0]  run_ctrl_r;
   reg         main_sel_r;
   reg         sub_sel_r;
   reg  [7:0]  sub_supply_r;
   reg  [`SCG_STAB_CNT_W-1:0] stab_cnt_r;
   reg         main_run_d_r;
   reg  [7:0]  rd_mux;
   reg         addr_ok;
   wire [1:0]  cur_src;
   wire [1:0]  req_src;
   wire        wr_en;
   wire        main_run;
   wire [7:0]  stab_flags;
   wire [4:0]  freq_code;

   // printed offsets are indices; byte address is four times the index
   function is_reg;
      input [23:0] addr;
      input [23:0] idx;
      begin
         is_reg = (addr == {idx[21:0], 2'b00});
      end
   endfunction

   function freq_code_ok;
      input [4:0] c;
      begin
         freq_code_ok = (c[2:0] == 3'h0) |
                        (!c[4] & (!c[2] | (c[3] & (c[2:1] == 2'b10))));
      end
   endfunction

   function div_ok;
      input       fam_hi;
      input [2:0] d;
      begin
         div_ok = !d[2] | (fam_hi & !d[1]);
      end
   endfunction

   function [7:0] fih_mhz;
      input       fam_hi;
      input [2:0] d;
      reg   [7:0] base;
      begin
         base = fam_hi ? `SCG_BASE_HI_MHZ : `SCG_BASE_LO_MHZ;
         case (d)
            3'h0, 3'h1, 3'h2, 3'h3: fih_mhz = base >> d[1:0];
            3'h4:    fih_mhz = fam_hi ? `SCG_DIV4_MHZ : 8'h00;
            3'h5:    fih_mhz = fam_hi ? `SCG_DIV5_MHZ : 8'h00;
            default: fih_mhz = 8'h00;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_s1_r <= 8'h00;
         opt_s2_r <= 8'h00;
         sup_s1_r <= 1'b0;
         sup_s2_r <= 1'b0;
         mx_s1_r  <= 1'b0;
         mx_s2_r  <= 1'b0;
         mx_s3_r  <= 1'b0;
      end else begin
         opt_s1_r <= boot_option;
         opt_s2_r <= opt_s1_r;
         sup_s1_r <= supply_ok;
         sup_s2_r <= sup_s1_r;
         mx_s1_r  <= main_xtal_clk;
         mx_s2_r  <= mx_s1_r;
         mx_s3_r  <= mx_s2_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reset processing; option byte is caught once supply is good
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rp_state_r  <= RP_SUPPLY;
         rp_cnt_r    <= 16'h0000;
         boot_opt_r  <= 8'h00;
         cpu_reset_n <= 1'b0;
      end else begin
         case (rp_state_r)
            RP_SUPPLY: begin
               if (sup_s2_r) begin
                  boot_opt_r <= opt_s2_r;
                  rp_cnt_r   <= RST_PROC_CYC[15:0];
                  rp_state_r <= RP_COUNT;
               end
            end
            RP_COUNT: begin
               // covers fast oscillator accuracy stabilization
               if (!sup_s2_r) begin
                  rp_state_r <= RP_SUPPLY;
               end else if (rp_cnt_r <= 16'h0001) begin
                  cpu_reset_n <= 1'b1;
                  rp_state_r  <= RP_DONE;
               end else begin
                  rp_cnt_r <= rp_cnt_r - 16'h0001;
               end
            end
            RP_DONE: cpu_reset_n <= 1'b1;
            default: rp_state_r <= RP_SUPPLY;
         endcase
      end
   end

   assign freq_code  = {boot_opt_r[`SCG_OPT_FREQ_HI:`SCG_OPT_FREQ_B3],
                        boot_opt_r[2:0]};
   assign flash_mode = {boot_opt_r[`SCG_OPT_FLASH_HI], boot_opt_r[`SCG_OPT_FLASH_LO]};

   ////////////////////////////////////////////////////////////////////////
   // apb slave: zero wait states, read data caught in the setup cycle
   assign pready = 1'b1;
   assign wr_en  = psel & penable & pwrite & addr_ok;

   always @* begin
      addr_ok = 1'b1;
      rd_mux  = 8'h00;
      if (is_reg(paddr, `SCG_IDX_BOOT_OPT)) begin
         rd_mux = boot_opt_r;
      end else if (is_reg(paddr, `SCG_IDX_FAST_DIV)) begin
         rd_mux = {5'h00, fast_div_r};
      end else if (is_reg(paddr, `SCG_IDX_OSC_MODE)) begin
         rd_mux = osc_mode_r;
      end else if (is_reg(paddr, `SCG_IDX_STAB_SEL)) begin
         rd_mux = {5'h00, stab_sel_r};
      end else if (is_reg(paddr, `SCG_IDX_RUN_CTRL)) begin
         rd_mux = run_ctrl_r;
      end else if (is_reg(paddr, `SCG_IDX_STAB_STAT)) begin
         rd_mux = stab_flags;
      end else if (is_reg(paddr, `SCG_IDX_SYS_CLK)) begin
         rd_mux = {cur_src == `SCG_SRC_SUB, sub_sel_r,
                   cur_src == `SCG_SRC_MAIN, main_sel_r, 4'h0};
      end else if (is_reg(paddr, `SCG_IDX_SUB_SUPPLY)) begin
         rd_mux = sub_supply_r;
      end else begin
         addr_ok = 1'b0;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel & !penable) begin
         prdata  <= {24'h000000, rd_mux};
         pslverr <= !addr_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_div_r     <= 3'h0;
         osc_mode_r     <= `SCG_RST_OSC_MODE;
         mode_written_r <= 1'b0;
         stab_sel_r     <= `SCG_RST_STAB_SEL;
         run_ctrl_r     <= `SCG_RST_RUN_CTRL;
         main_sel_r     <= 1'b0;
         sub_sel_r      <= 1'b0;
         sub_supply_r   <= `SCG_RST_SUB_SUPPLY;
      end else begin
         if ((rp_state_r == RP_SUPPLY) & sup_s2_r) begin
            // option code low bits double as the starting divider
            fast_div_r <= opt_s2_r[2:0];
         end else if (wr_en & is_reg(paddr, `SCG_IDX_FAST_DIV) &
                      div_ok(freq_code[3], pwdata[2:0])) begin
            fast_div_r <= pwdata[2:0];
         end
         if (wr_en & is_reg(paddr, `SCG_IDX_OSC_MODE) & !mode_written_r) begin
            osc_mode_r     <= pwdata[7:0] & 8'hF7;
            mode_written_r <= 1'b1;
         end
         if (wr_en & is_reg(paddr, `SCG_IDX_STAB_SEL)) begin
            stab_sel_r <= pwdata[2:0];
         end
         if (wr_en & is_reg(paddr, `SCG_IDX_RUN_CTRL)) begin
            run_ctrl_r[`SCG_RUN_MAIN_HALT] <= pwdata[`SCG_RUN_MAIN_HALT] &
                                              (cur_src != `SCG_SRC_MAIN);
            run_ctrl_r[`SCG_RUN_SUB_HALT]  <= pwdata[`SCG_RUN_SUB_HALT] &
                                              (cur_src != `SCG_SRC_SUB);
            // the source feeding the cpu cannot be stopped
            run_ctrl_r[`SCG_RUN_FAST_HALT] <= pwdata[`SCG_RUN_FAST_HALT] &
                                              (cur_src != `SCG_SRC_FAST) &
                                              (req_src != `SCG_SRC_FAST);
         end
         if (wr_en & is_reg(paddr, `SCG_IDX_SYS_CLK)) begin
            main_sel_r <= pwdata[`SCG_SYS_MAIN_SEL];
            sub_sel_r  <= pwdata[`SCG_SYS_SRC_SUB];
         end
         if (wr_en & is_reg(paddr, `SCG_IDX_SUB_SUPPLY)) begin
            sub_supply_r <= pwdata[7:0] & 8'h90;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fast oscillator frequency
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_osc_mhz     <= 8'h00;
         fast_osc_raw_mhz <= 8'h00;
      end else if (!freq_code_ok(freq_code)) begin
         fast_osc_mhz     <= 8'h00;
         fast_osc_raw_mhz <= 8'h00;
      end else begin
         fast_osc_mhz     <= fih_mhz(freq_code[3], fast_div_r);
         // top code bit: raw clock twice the selected one
         fast_osc_raw_mhz <= freq_code[4] ?
                             (fih_mhz(freq_code[3], fast_div_r) << 1) :
                             fih_mhz(freq_code[3], fast_div_r);
      end
   end

   assign fast_osc_en = !run_ctrl_r[`SCG_RUN_FAST_HALT];

   ////////////////////////////////////////////////////////////////////////
   // oscillator enables from pin mode pair and halt bits
   assign main_run        = !run_ctrl_r[`SCG_RUN_MAIN_HALT] & osc_mode_r[`SCG_MODE_MAIN_PIN];
   assign main_osc_en     = main_run & !osc_mode_r[`SCG_MODE_MAIN_EXT];
   assign main_ext_clk_en = main_run & osc_mode_r[`SCG_MODE_MAIN_EXT];
   assign main_gain_high  = osc_mode_r[`SCG_MODE_MAIN_GAIN];
   assign sub_osc_en      = !run_ctrl_r[`SCG_RUN_SUB_HALT] &
                            osc_mode_r[`SCG_MODE_SUB_PIN] &
                            !osc_mode_r[`SCG_MODE_SUB_EXT];
   assign sub_ext_clk_en  = !run_ctrl_r[`SCG_RUN_SUB_HALT] &
                            osc_mode_r[`SCG_MODE_SUB_PIN] &
                            osc_mode_r[`SCG_MODE_SUB_EXT];
   assign sub_drive_mode  = {osc_mode_r[`SCG_MODE_SUB_DRV_HI],
                             osc_mode_r[`SCG_MODE_SUB_DRV_LO]};
   assign stab_time_sel   = stab_sel_r;

   ////////////////////////////////////////////////////////////////////////
   // stabilization counter on main oscillator rising edges
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stab_cnt_r   <= {`SCG_STAB_CNT_W{1'b0}};
         main_run_d_r <= 1'b0;
      end else begin
         main_run_d_r <= main_run;
         if (!main_run | !main_run_d_r) begin
            stab_cnt_r <= {`SCG_STAB_CNT_W{1'b0}};
         end else if (mx_s2_r & !mx_s3_r & !stab_cnt_r[`SCG_STAB_CNT_W-1]) begin
            stab_cnt_r <= stab_cnt_r + {{(`SCG_STAB_CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // elapsed at 2^8,9,10,11,13,15,17,18 cycles, bit 7 first
   assign stab_flags = {|stab_cnt_r[18:8],  |stab_cnt_r[18:9],
                        |stab_cnt_r[18:10], |stab_cnt_r[18:11],
                        |stab_cnt_r[18:13], |stab_cnt_r[18:15],
                        |stab_cnt_r[18:17], stab_cnt_r[18]};

   ////////////////////////////////////////////////////////////////////////
   // cpu clock source: sub select wins over main select
   assign req_src = sub_sel_r  ? `SCG_SRC_SUB  :
                    main_sel_r ? `SCG_SRC_MAIN : `SCG_SRC_FAST;

   scg_src_switch #(
      .GAP_CYC    (GAP_CYC)
   ) u_switch (
      .pclk       (pclk),
      .presetn    (presetn),
      .req_src    (req_src),
      .cur_src    (cur_src),
      .sel_onehot (clk_sel_onehot)
   );

   // low power: only rtc and interval timer keep the sub clock in standby while the cpu runs on sub clock
   assign sub_clk_rtc_en    = 1'b1;
   assign sub_clk_periph_en = !(sub_supply_r[`SCG_SUP_LOW_POWER] &
                                (cur_src == `SCG_SRC_SUB) & cpu_standby);

endmodule
`default_nettype wire

// [sim/scg_clock_ctrl_checker.sv]
// Purpose: port-level assertions for scg_clock_ctrl
// Assumes: one pclk domain, presetn asynchronous active low
// Notes:   bound into every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module scg_clock_ctrl_checker #(
   parameter RST_PROC_CYC = 8,
   parameter GAP_CYC      = 4
) (
   input wire logic        pclk,              // clock
   input wire logic        presetn,           // reset, active low
   input wire logic        psel,              // apb select
   input wire logic        penable,           // apb enable
   input wire logic [31:0] prdata,            // apb read data
   input wire logic        supply_ok,         // supply in range
   input wire logic        cpu_reset_n,       // internal reset
   input wire logic        cpu_standby,       // cpu stop or halt
   input wire logic        fast_osc_en,       // fast osc run
   input wire logic        main_osc_en,       // main resonator run
   input wire logic        main_ext_clk_en,   // main external run
   input wire logic        sub_osc_en,        // sub resonator run
   input wire logic        sub_ext_clk_en,    // sub external run
   input wire logic [2:0]  clk_sel_onehot,    // cpu mux selects
   input wire logic        sub_clk_periph_en  // sub clock to peripherals
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
////////////////////////////////////////////////////////////////////////////////
logic [3:0] zero_cnt_r;
logic [3:0] zero_cnt_nxt;
assign zero_cnt_nxt = (clk_sel_onehot == 3'h0) ? zero_cnt_r + 4'h1 : 4'h0;
always @(posedge pclk or negedge presetn) begin
   if (!presetn) zero_cnt_r <= 4'h0;
   else zero_cnt_r <= zero_cnt_nxt;
end
sequence leave_src;
   clk_sel_onehot != 3'h0 ##1 clk_sel_onehot == 3'h0;
endsequence
////////////////////////////////////////////////////////////////////////////////
onehot_sel_a: assert property ($onehot0(clk_sel_onehot))
   else $error("cpu clock selects not one-hot");
gap_exact_a: assert property (clk_sel_onehot != 3'h0 && $past(clk_sel_onehot) == 3'h0
   |-> zero_cnt_r == GAP_CYC) else $error("switch gap length wrong");
gap_bound_a: assert property (leave_src |-> ##[1:16] clk_sel_onehot != 3'h0)
   else $error("switch never completed");
fast_kept_a: assert property (clk_sel_onehot[0] |-> fast_osc_en)
   else $error("fast oscillator stopped while in use");
main_kept_a: assert property (clk_sel_onehot[1] |-> main_osc_en || main_ext_clk_en)
   else $error("main source selected but not running");
sub_kept_a: assert property (clk_sel_onehot[2] |-> sub_osc_en || sub_ext_clk_en)
   else $error("sub source selected but not running");
read_upper_a: assert property (psel && !penable |=> prdata[31:8] == 24'h0)
   else $error("read data upper bits not zero");
cpu_release_a: assert property ($rose(cpu_reset_n) |-> $past(supply_ok, 9))
   else $error("cpu released without supply");
periph_gate_a: assert property (!sub_clk_periph_en |-> cpu_standby)
   else $error("peripheral sub clock gated outside standby");
pin_pair_a: assert property (!(main_osc_en && main_ext_clk_en))
   else $error("main resonator and external input both on");
endmodule
bind scg_clock_ctrl scg_clock_ctrl_checker #(.RST_PROC_CYC(RST_PROC_CYC), .GAP_CYC(GAP_CYC))
   u_chk (.pclk, .presetn, .psel, .penable, .prdata, .supply_ok, .cpu_reset_n, .cpu_standby,
   .fast_osc_en, .main_osc_en, .main_ext_clk_en, .sub_osc_en, .sub_ext_clk_en,
   .clk_sel_onehot, .sub_clk_periph_en);
`default_nettype wire

// [sim/test_system_clock_generator_control.sv]
// Purpose: directed register-level test of scg_clock_ctrl
// Assumes: short reset processing count of 8 cycles
// Notes:   main crystal modelled at 12.5 MHz, still while halted
`timescale 1ns/1ps
`default_nettype none
`include "scg_defines.vh"
module test_system_clock_generator_control;
logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [23:0] paddr = 24'h0;
logic [31:0] pwdata = 32'h0, prdata, rd;
logic [7:0]  boot_option = 8'hC8, fast_osc_mhz, raw_mhz;
logic        supply_ok = 1'b0, main_xtal_clk = 1'b0, cpu_standby = 1'b0, err;
logic        pready, pslverr, cpu_reset_n, fast_osc_en, main_osc_en, main_ext_clk_en;
logic        main_gain_high, sub_osc_en, sub_ext_clk_en, sub_clk_periph_en, sub_clk_rtc_en;
logic [1:0]  flash_mode, sub_drive_mode, xdiv = 2'h0;
logic [2:0]  clk_sel_onehot, stab_time_sel;
int          miscompares = 0, num_checks = 0, cyc = 0, i;
always #10 pclk = ~pclk;
always @(posedge pclk) begin
   xdiv <= xdiv + 2'h1;
   main_xtal_clk <= main_osc_en & xdiv[1];
   cyc <= cyc + 1;
   if (cyc == 20000) begin
      miscompares = miscompares + 1;
      wrap_up();
   end
end
scg_clock_ctrl #(.RST_PROC_CYC(8), .GAP_CYC(4)) DUT (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .boot_option, .supply_ok,
   .main_xtal_clk, .cpu_standby, .cpu_reset_n, .fast_osc_en, .main_osc_en, .main_ext_clk_en,
   .main_gain_high, .sub_osc_en, .sub_ext_clk_en, .sub_drive_mode, .fast_osc_mhz,
   .fast_osc_raw_mhz(raw_mhz), .flash_mode, .stab_time_sel, .clk_sel_onehot, .sub_clk_periph_en,
   .sub_clk_rtc_en);
////////////////////////////////////////////////////////////////////////////////
task automatic apb(input logic [23:0] idx, input logic wr, input logic [7:0] wd);
   @(posedge pclk);
   psel <= 1'b1;
   pwrite <= wr;
   paddr <= {idx[21:0], 2'b00};
   pwdata <= {24'h0, wd};
   @(posedge pclk);
   penable <= 1'b1;
   @(posedge pclk);
   while (pready !== 1'b1) @(posedge pclk);
   rd = prdata;
   err = pslverr;
   psel <= 1'b0;
   penable <= 1'b0;
   // let registers written at the access edge settle before callers look
   @(posedge pclk);
endtask
task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
   num_checks = num_checks + 1;
   if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
   end
endtask
task automatic wrap_up();
   $display("checks %0d mismatches %0d", num_checks, miscompares);
   if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
   else $display("Simulation failed");
   $finish;
endtask
task automatic boot();
   presetn <= 1'b0;
   supply_ok <= 1'b0;
   repeat (3) @(posedge pclk);
   presetn <= 1'b1;
   repeat (5) @(posedge pclk);
   check("cpu reset", cpu_reset_n, 1'b0);
   supply_ok <= 1'b1;
   for (i = 0; i < 40 && cpu_reset_n !== 1'b1; i++) @(posedge pclk);
   check("cpu release", cpu_reset_n, 1'b1);
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
   boot();
   check("start select", clk_sel_onehot, 3'b001);
   check("fast on", fast_osc_en, 1'b1);
   check("crystals off", {main_osc_en, sub_osc_en}, 2'b00);
   check("fast MHz", fast_osc_mhz, 8'h20);
   check("flash mode", flash_mode, 2'b11);
   apb(`SCG_IDX_RUN_CTRL, 1'b0, 8'h0);
   check("run reset", rd, 32'hC0);
   apb(`SCG_IDX_BOOT_OPT, 1'b1, 8'h0);
   apb(`SCG_IDX_BOOT_OPT, 1'b0, 8'h0);
   check("option", rd, 32'hC8);
   for (i = 0; i < 6; i++) begin
      apb(`SCG_IDX_FAST_DIV, 1'b1, i[7:0]);
      repeat (2) @(posedge pclk);
      check("divided MHz", fast_osc_mhz, 8'h20 >> i);
   end
   apb(`SCG_IDX_FAST_DIV, 1'b1, 8'hFF);
   apb(`SCG_IDX_FAST_DIV, 1'b0, 8'h0);
   check("divider", rd, 32'h5);
   apb(`SCG_IDX_OSC_MODE, 1'b1, 8'h55);
   apb(`SCG_IDX_OSC_MODE, 1'b1, 8'h0);
   apb(`SCG_IDX_OSC_MODE, 1'b0, 8'h0);
   check("mode once", rd, 32'h55);
   check("gain", main_gain_high, 1'b1);
   check("sub drive", sub_drive_mode, 2'b10);
   apb(`SCG_IDX_STAB_SEL, 1'b1, 8'h2);
   check("stab select", stab_time_sel, 3'h2);
   apb(`SCG_IDX_RUN_CTRL, 1'b1, 8'h0);
   check("osc run", {main_osc_en, sub_osc_en, main_ext_clk_en}, 3'b110);
   // the write above left the old run control value in rd
   rd = 32'h0;
   for (i = 0; i < 900 && rd[7] !== 1'b1; i++) apb(`SCG_IDX_STAB_STAT, 1'b0, 8'h0);
   check("stab flags", rd, 32'h80);
   apb(`SCG_IDX_SYS_CLK, 1'b1, 8'h10);
   repeat (8) @(posedge pclk);
   check("main select", clk_sel_onehot, 3'b010);
   apb(`SCG_IDX_SYS_CLK, 1'b0, 8'h0);
   check("main status", rd, 32'h30);
   apb(`SCG_IDX_RUN_CTRL, 1'b1, 8'h01);
   check("fast halt", fast_osc_en, 1'b0);
   repeat (40) @(posedge pclk);
   apb(`SCG_IDX_SYS_CLK, 1'b1, 8'h50);
   repeat (8) @(posedge pclk);
   check("sub select", clk_sel_onehot, 3'b100);
   apb(`SCG_IDX_SYS_CLK, 1'b0, 8'h0);
   check("sub status", rd, 32'hD0);
   apb(`SCG_IDX_SUB_SUPPLY, 1'b1, 8'h80);
   cpu_standby <= 1'b1;
   repeat (2) @(posedge pclk);
   check("periph gate", {sub_clk_periph_en, sub_clk_rtc_en}, 2'b01);
   cpu_standby <= 1'b0;
   apb(`SCG_IDX_RUN_CTRL, 1'b1, 8'hC0);
   apb(`SCG_IDX_RUN_CTRL, 1'b0, 8'h0);
   check("sub kept", rd, 32'h80);
   apb(`SCG_IDX_STAB_STAT, 1'b0, 8'h0);
   check("stab cleared", rd, 32'h0);
   apb(24'h0F00BF, 1'b0, 8'h0);
   check("unmapped", err, 1'b1);
   boot_option <= 8'hD0;
   boot();
   check("halved MHz", fast_osc_mhz, 8'h18);
   check("raw MHz", raw_mhz, 8'h30);
   apb(`SCG_IDX_OSC_MODE, 1'b1, 8'hC0);
   apb(`SCG_IDX_RUN_CTRL, 1'b1, 8'h40);
   check("ext in", {main_osc_en, main_ext_clk_en}, 2'b01);
   apb(`SCG_IDX_SYS_CLK, 1'b1, 8'h10);
   repeat (8) @(posedge pclk);
   check("ext select", clk_sel_onehot, 3'b010);
   wrap_up();
end
endmodule
`default_nettype wire
